// >>> logic/tmw_pkg.sv
`default_nettype none
package tmw_pkg;
    // *****************************
    // register map
    // *****************************
    localparam logic [11:0] ADDR_CTRL_A = 12'h080;
    localparam logic [11:0] ADDR_CTRL_B = 12'h084;
    localparam logic [11:0] ADDR_CMP_A = 12'h088;
    localparam logic [11:0] ADDR_CMP_B = 12'h08c;
    localparam logic [11:0] ADDR_CAPT = 12'h090;
    localparam logic [11:0] ADDR_COUNT = 12'h094;
    localparam logic [11:0] ADDR_STATUS = 12'h098;
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_A_MASK = 8'hf3;
    localparam int OM_A_HI = 7;
    localparam int OM_A_LO = 6;
    localparam int OM_B_HI = 5;
    localparam int OM_B_LO = 4;
    localparam logic [15:0] TOP_8 = 16'h00ff;
    localparam logic [15:0] TOP_9 = 16'h01ff;
    localparam logic [15:0] TOP_10 = 16'h03ff;
    localparam logic [15:0] MAX = 16'hffff;
    localparam logic [15:0] BOTTOM = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        TMW_KIND_NORMAL = 2'b00,
        TMW_KIND_CLEAR = 2'b01,
        TMW_KIND_FAST = 2'b10,
        TMW_KIND_DUAL = 2'b11
    } tmw_kind_t;
endpackage : tmw_pkg
`default_nettype wire

// >>> logic/tmw_cfg_if.sv
`default_nettype none
// mode decode handed from the core to each output channel
interface tmw_cfg_if;
    logic tick;
    logic [1:0] kind;
    logic [3:0] mode;
    logic counting_up;
    logic at_top;
    logic at_bottom;
    logic [15:0] count;
    logic [15:0] top;
    modport core (output tick, kind, mode, counting_up, at_top, at_bottom,
        count, top);
    modport chan (input tick, kind, mode, counting_up, at_top, at_bottom,
        count, top);
endinterface : tmw_cfg_if
`default_nettype wire

// >>> logic/tmw_chan.sv
`default_nettype none
module tmw_chan #(
    parameter bit IS_A = 1'b1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // mode from core
    tmw_cfg_if.chan cfg,
    // channel setup
    input wire logic [1:0] out_mode,
    input wire logic [15:0] compare_value_n,
    input wire logic dir_out,
    // outputs
    output logic wave_level,
    output logic pin_override,
    output logic pin_oe
);
    // *****************************
    // action decode
    // *****************************
    logic match;
    logic tog_ok;
    logic next_level;
    assign match = cfg.tick && (cfg.count == compare_value_n);
    // fast and dual kinds toggle only for channel A; fast kinds with bit 3 are modes 14 and 15
    always_comb begin
        unique case (tmw_pkg::tmw_kind_t'(cfg.kind))
            tmw_pkg::TMW_KIND_FAST: tog_ok = IS_A && cfg.mode[3];
            tmw_pkg::TMW_KIND_DUAL:
                tog_ok = IS_A && cfg.mode[0] && cfg.mode[3];
            default: tog_ok = 1'b1;
        endcase
    end

    // next output level per mode kind
    always_comb begin
        next_level = wave_level;
        unique case (tmw_pkg::tmw_kind_t'(cfg.kind))
            tmw_pkg::TMW_KIND_FAST: begin
                // match at TOP is ignored, BOTTOM action still taken
                if (out_mode[1] && match && compare_value_n != cfg.top)
                    next_level = out_mode[0];
                else if (out_mode[1] && cfg.tick && cfg.at_top)
                    next_level = ~out_mode[0];
                else if (out_mode == 2'b01 && tog_ok && match)
                    next_level = ~wave_level;
            end
            tmw_pkg::TMW_KIND_DUAL: begin
                // extremes pin the level, else a match sets or clears it by counting direction
                if (out_mode[1] && match && compare_value_n == cfg.top)
                    next_level = ~out_mode[0];
                else if (out_mode[1] && match &&
                        compare_value_n == tmw_pkg::BOTTOM)
                    next_level = out_mode[0];
                else if (out_mode[1] && match)
                    next_level = out_mode[0] ^ ~cfg.counting_up;
                else if (out_mode == 2'b01 && tog_ok && match)
                    next_level = ~wave_level;
            end
            default: begin
                if (match && out_mode != 2'b00)
                    next_level = out_mode[1] ? out_mode[0] : ~wave_level;
            end
        endcase
    end

    // waveform register, updated only on a tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wave_level <= 1'b0;
        end else begin
            wave_level <= next_level;
        end
    end

    // pin steering
    assign pin_override = (out_mode[1] || tog_ok) &&
        (out_mode != 2'b00);
    assign pin_oe = pin_override && dir_out;

    a_off_no_drive: assert property (
        @(posedge aclk) disable iff (!aresetn) (!dir_out |-> !pin_oe))
        else $error("pin driven while input");
    a_none_no_ovr: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (out_mode == 2'b00 |-> !pin_override))
        else $error("override with field zero");
    a_fast_clear: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (cfg.kind == 2'b10 && out_mode == 2'b10 && match && !cfg.at_top
        && compare_value_n != cfg.top |=> !wave_level))
        else $error("fast pwm did not clear on match");
    a_dual_up_clear: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (cfg.kind == 2'b11 && out_mode == 2'b10 && match && cfg.counting_up
        && compare_value_n != cfg.top |=> !wave_level))
        else $error("dual slope up match");
    c_toggle: cover property (@(posedge aclk) match && out_mode == 2'b01);
endmodule : tmw_chan
`default_nettype wire

// >>> logic/tmw_top.sv
// Local design decision: register access over AXI4-Lite.
`default_nettype none
module tmw_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // timer tick and pin direction
    input wire logic timer_tick,
    input wire logic dir_out_a,
    input wire logic dir_out_b,
    // pins
    output logic wave_out_a,
    output logic wave_out_b,
    output logic wave_oe_a,
    output logic wave_oe_b,
    output logic override_a,
    output logic override_b,
    output logic capture_pin_enable,
    output logic overflow_flag
);
    // *****************************
    // registers
    // *****************************
    logic [7:0] timer16_control_a;
    logic [1:0] wave_mode_hi;
    logic [15:0] compare_value_a;
    logic [15:0] compare_value_b;
    logic [15:0] buf_a;
    logic [15:0] buf_b;
    logic [15:0] capture_value;
    logic [15:0] count_value;
    logic counting_up;
    logic [3:0] wave_mode_sel;
    logic [1:0] kind;
    logic [15:0] top;
    logic at_top;
    logic at_bottom;
    logic load_now;
    logic ovf_now;
    logic have_aw;
    logic have_w;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_word;

    assign wave_mode_sel = {wave_mode_hi, timer16_control_a[1:0]};

    // *****************************
    // mode decode
    // *****************************
    always_comb begin
        unique case (wave_mode_sel)
            4'd0: kind = tmw_pkg::TMW_KIND_NORMAL;
            4'd4, 4'd12, 4'd13: kind = tmw_pkg::TMW_KIND_CLEAR;
            4'd5, 4'd6, 4'd7, 4'd14, 4'd15: kind = tmw_pkg::TMW_KIND_FAST;
            default: kind = tmw_pkg::TMW_KIND_DUAL;
        endcase
    end

    // top source per mode; reserved 13 behaves as a free counter
    always_comb begin
        unique case (wave_mode_sel)
            4'd1, 4'd5: top = tmw_pkg::TOP_8;
            4'd2, 4'd6: top = tmw_pkg::TOP_9;
            4'd3, 4'd7: top = tmw_pkg::TOP_10;
            4'd4, 4'd9, 4'd11, 4'd15: top = compare_value_a;
            4'd8, 4'd10, 4'd12, 4'd14: top = capture_value;
            default: top = tmw_pkg::MAX;
        endcase
    end

    assign at_top = (count_value == top);
    assign at_bottom = (count_value == tmw_pkg::BOTTOM);
    assign capture_pin_enable = !(wave_mode_sel == 4'd8 ||
        wave_mode_sel == 4'd10 || wave_mode_sel == 4'd12 ||
        wave_mode_sel == 4'd14);

    // buffer load and overflow events; normal and clear kinds load without a tick
    always_comb begin
        load_now = 1'b0;
        ovf_now = 1'b0;
        unique case (tmw_pkg::tmw_kind_t'(kind))
            tmw_pkg::TMW_KIND_FAST: begin
                load_now = at_bottom;
                ovf_now = at_top;
            end
            tmw_pkg::TMW_KIND_DUAL: begin
                load_now = wave_mode_sel[3] && !wave_mode_sel[1] ?
                    at_bottom : at_top;
                ovf_now = at_bottom && !counting_up;
            end
            default: begin
                load_now = 1'b1;
                ovf_now = (count_value == tmw_pkg::MAX);
            end
        endcase
    end

    // counter, only advanced on a tick of aclk
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_value <= tmw_pkg::BOTTOM;
            counting_up <= 1'b1;
        end else if (timer_tick) begin
            if (kind == tmw_pkg::TMW_KIND_DUAL) begin
                if (at_top && counting_up) begin
                    counting_up <= 1'b0;
                    count_value <= count_value - 16'h0001;
                end else if (at_bottom && !counting_up) begin
                    counting_up <= 1'b1;
                    count_value <= count_value + 16'h0001;
                end else if (counting_up) begin
                    count_value <= count_value + 16'h0001;
                end else begin
                    count_value <= count_value - 16'h0001;
                end
            end else begin
                counting_up <= 1'b1;
                count_value <= at_top ? tmw_pkg::BOTTOM :
                    count_value + 16'h0001;
            end
        end
    end

    // active compare values, loaded from buffers per mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_value_a <= 16'h0000;
            compare_value_b <= 16'h0000;
        end else if (load_now && (timer_tick || kind[1] == 1'b0)) begin
            compare_value_a <= buf_a;
            compare_value_b <= buf_b;
        end
    end

    // sticky overflow flag; set beats software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_flag <= 1'b0;
        end else if (timer_tick && ovf_now) begin
            overflow_flag <= 1'b1;
        end else if (wr_hit && aw_addr == tmw_pkg::ADDR_STATUS &&
                w_strb[0] && w_data[0]) begin
            overflow_flag <= 1'b0;
        end
    end

    // *****************************
    // axi4-lite slave
    // *****************************
    assign s_axi_awready = !have_aw && !s_axi_bvalid;
    assign s_axi_wready = !have_w && !s_axi_bvalid;
    assign wr_go = have_aw && have_w && !s_axi_bvalid;
    assign wr_hit = wr_go;

    // capture address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            have_aw <= 1'b0;
            have_w <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (wr_go) begin
            have_aw <= 1'b0;
            have_w <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                have_aw <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                have_w <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    // register writes; reserved bits dropped by the mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer16_control_a <= tmw_pkg::CTRL_A_RESET;
            wave_mode_hi <= 2'b00;
            buf_a <= 16'h0000;
            buf_b <= 16'h0000;
            capture_value <= 16'h0000;
        end else if (wr_go) begin
            unique case (aw_addr)
                tmw_pkg::ADDR_CTRL_A: if (w_strb[0])
                    timer16_control_a <= w_data[7:0] &
                        tmw_pkg::CTRL_A_MASK;
                tmw_pkg::ADDR_CTRL_B: if (w_strb[0])
                    wave_mode_hi <= w_data[4:3];
                tmw_pkg::ADDR_CMP_A: buf_a <= w_data[15:0];
                tmw_pkg::ADDR_CMP_B: buf_b <= w_data[15:0];
                tmw_pkg::ADDR_CAPT: capture_value <= w_data[15:0];
                default: ;
            endcase
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tmw_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == tmw_pkg::ADDR_COUNT ||
                aw_addr[11:8] != 4'h0 || aw_addr > tmw_pkg::ADDR_STATUS ||
                aw_addr < tmw_pkg::ADDR_CTRL_A) ?
                tmw_pkg::RESP_SLVERR : tmw_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read mux
    always_comb begin
        rd_hit = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (s_axi_araddr)
            tmw_pkg::ADDR_CTRL_A: rd_word[7:0] = timer16_control_a;
            tmw_pkg::ADDR_CTRL_B: rd_word[4:3] = wave_mode_hi;
            tmw_pkg::ADDR_CMP_A: rd_word[15:0] = buf_a;
            tmw_pkg::ADDR_CMP_B: rd_word[15:0] = buf_b;
            tmw_pkg::ADDR_CAPT: rd_word[15:0] = capture_value;
            tmw_pkg::ADDR_COUNT: rd_word[15:0] = count_value;
            tmw_pkg::ADDR_STATUS: rd_word[1:0] = {counting_up, overflow_flag};
            default: rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= tmw_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? tmw_pkg::RESP_OKAY : tmw_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // *****************************
    // channels
    // *****************************
    tmw_cfg_if cfg ();
    assign cfg.tick = timer_tick;
    assign cfg.kind = kind;
    assign cfg.mode = wave_mode_sel;
    assign cfg.counting_up = counting_up;
    assign cfg.at_top = at_top;
    assign cfg.at_bottom = at_bottom;
    assign cfg.count = count_value;
    assign cfg.top = top;

    tmw_chan #(.IS_A(1'b1)) u_chan_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(cfg),
        .out_mode(timer16_control_a[tmw_pkg::OM_A_HI:tmw_pkg::OM_A_LO]),
        .compare_value_n(compare_value_a),
        .dir_out(dir_out_a),
        .wave_level(wave_out_a),
        .pin_override(override_a),
        .pin_oe(wave_oe_a)
    );
    tmw_chan #(.IS_A(1'b0)) u_chan_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(cfg),
        .out_mode(timer16_control_a[tmw_pkg::OM_B_HI:tmw_pkg::OM_B_LO]),
        .compare_value_n(compare_value_b),
        .dir_out(dir_out_b),
        .wave_level(wave_out_b),
        .pin_override(override_b),
        .pin_oe(wave_oe_b)
    );

    // *****************************
    // checks
    // *****************************
    a_hold_no_tick: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (!timer_tick |=> $stable(count_value)))
        else $error("counter moved without tick");
    a_reserved_zero: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (timer16_control_a[3:2] == 2'b00))
        else $error("reserved bits set");
    a_normal_ovf: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (wave_mode_sel == 4'd0 && timer_tick && count_value == 16'hffff
        |=> overflow_flag && count_value == 16'h0000))
        else $error("normal mode overflow");
    a_capt_off: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (wave_mode_sel == 4'd12 |-> !capture_pin_enable))
        else $error("capture pin live");
    c_fast: cover property (@(posedge aclk) kind == 2'b10 && at_top);
    c_dual: cover property (@(posedge aclk) kind == 2'b11 && !counting_up);
    c_ovf: cover property (@(posedge aclk) $rose(overflow_flag));
endmodule : tmw_top
`default_nettype wire

// >>> testbench/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************
    // stimulus, observation and counters
    // ************************************
    localparam int LIMIT = 40000;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] aw_addr = 12'h000;
    logic [11:0] ar_addr = 12'h000;
    logic [31:0] w_data = 32'h0000_0000;
    logic [3:0] w_strb = 4'hf;
    logic aw_valid = 1'b0;
    logic w_valid = 1'b0;
    logic b_ready = 1'b0;
    logic ar_valid = 1'b0;
    logic r_ready = 1'b0;
    logic timer_tick = 1'b1;
    logic dir_out_a = 1'b1;
    logic dir_out_b = 1'b1;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
    logic [1:0] b_resp, r_resp;
    logic [31:0] r_data;
    logic wave_out_a, wave_out_b, wave_oe_a, wave_oe_b;
    logic override_a, override_b, capture_pin_enable, overflow_flag;
    logic [31:0] rd_data;
    logic [1:0] rd_resp;
    int fail_count = 0;
    int num_checks = 0;
    int hi;
    int tg;

    // free-running clock, 8 ns period
    initial begin
        forever #4 aclk = ~aclk;
    end

    tmw_top dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid),
        .s_axi_awready(aw_ready), .s_axi_wdata(w_data),
        .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid),
        .s_axi_wready(w_ready), .s_axi_bresp(b_resp),
        .s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
        .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid),
        .s_axi_arready(ar_ready), .s_axi_rdata(r_data),
        .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
        .s_axi_rready(r_ready), .timer_tick(timer_tick),
        .dir_out_a(dir_out_a), .dir_out_b(dir_out_b),
        .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
        .wave_oe_a(wave_oe_a), .wave_oe_b(wave_oe_b),
        .override_a(override_a), .override_b(override_b),
        .capture_pin_enable(capture_pin_enable),
        .overflow_flag(overflow_flag));

    // ************************************
    // shared helpers
    // ************************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : chk

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge aclk);
        aw_addr <= a;
        w_data <= d;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        do begin
            @(posedge aclk);
            if (aw_valid && aw_ready) aw_valid <= 1'b0;
            if (w_valid && w_ready) w_valid <= 1'b0;
        end while (b_valid !== 1'b1);
        b_ready <= 1'b0;
        chk(b_resp, er, "write response");
    endtask : wr

    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        do begin
            @(posedge aclk);
            if (ar_valid && ar_ready) ar_valid <= 1'b0;
        end while (r_valid !== 1'b1);
        rd_data = r_data;
        rd_resp = r_resp;
        r_ready <= 1'b0;
    endtask : rd

    // restarts the counter from BOTTOM so every period is known
    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
    endtask : do_reset

    task automatic set_mode(input logic [3:0] m, input logic [1:0] oa,
                            input logic [1:0] ob);
        wr(tmw_pkg::ADDR_CTRL_B, {27'h0, m[3:2], 3'h0}, tmw_pkg::RESP_OKAY);
        wr(tmw_pkg::ADDR_CTRL_A, {24'h0, oa, ob, 2'b00, m[1:0]},
           tmw_pkg::RESP_OKAY);
    endtask : set_mode

    // high cycles and edges of channel a over n cycles, phase-free
    task automatic meas(input int n);
        logic last;
        hi = 0;
        tg = 0;
        @(negedge aclk);
        last = wave_out_a;
        repeat (n) begin
            @(negedge aclk);
            if (wave_out_a === 1'b1) hi++;
            if (wave_out_a !== last) tg++;
            last = wave_out_a;
        end
    endtask : meas

    // waits two periods so buffered compare values are in place
    task automatic pwm_case(input logic [3:0] m, input logic [15:0] c,
                            input logic [1:0] om, input int n);
        // counter held at BOTTOM while the mode passes through its halves
        @(posedge aclk);
        timer_tick <= 1'b0;
        do_reset();
        wr(tmw_pkg::ADDR_CMP_A, {16'h0, c}, tmw_pkg::RESP_OKAY);
        set_mode(m, om, 2'b00);
        timer_tick <= 1'b1;
        repeat (2 * n + 20) @(posedge aclk);
        meas(n);
    endtask : pwm_case

    // ************************************
    // scenarios
    // ************************************
    task automatic t_regs();
        rd(tmw_pkg::ADDR_CTRL_A);
        chk(rd_data, 32'h0000_0000, "control a reset");
        wr(tmw_pkg::ADDR_CTRL_A, 32'h0000_00ff, tmw_pkg::RESP_OKAY);
        rd(tmw_pkg::ADDR_CTRL_A);
        chk(rd_data, 32'h0000_00f3, "control a readback");
        rd(12'h0fc);
        chk(rd_resp, tmw_pkg::RESP_SLVERR, "unmapped read");
        wr(tmw_pkg::ADDR_COUNT, 32'h0000_0001, tmw_pkg::RESP_SLVERR);
    endtask : t_regs

    // code 01 on both channels in every mode, channel a direction alternating; then codes 10 and 11 in mode 5
    task automatic t_pins();
        logic ea;
        logic cls;
        for (int m = 0; m < 16; m++) begin
            set_mode(m[3:0], 2'b01, 2'b01);
            dir_out_a <= m[0];
            cls = (m == 0 || m == 4 || m == 12 || m == 13);
            ea = cls || m == 9 || m == 11 || m == 14 || m == 15;
            @(negedge aclk);
            chk(override_a, ea, "override a");
            chk(override_b, cls, "override b");
            chk(wave_oe_a, ea & m[0], "enable a");
            chk(capture_pin_enable, !(m == 8 || m == 10 || m == 12 ||
                m == 14), "capture pin");
        end
        set_mode(4'd5, 2'b10, 2'b11);
        dir_out_a <= 1'b1;
        dir_out_b <= 1'b0;
        @(negedge aclk);
        chk({override_a, override_b}, 2'b11, "override");
        chk(wave_oe_b, 1'b0, "enable b low");
        @(posedge aclk);
        dir_out_b <= 1'b1;
        @(negedge aclk);
        chk(wave_oe_b, 1'b1, "enable b high");
    endtask : t_pins

    // clear-on-compare with TOP 7: one event every 8 cycles
    task automatic t_ctc();
        pwm_case(4'd4, 16'h0007, 2'b01, 32);
        chk(tg, 4, "ctc toggles");
        set_mode(4'd4, 2'b11, 2'b11);
        meas(16);
        meas(16);
        chk(hi, 16, "ctc set");
        chk(wave_out_b, 1'b1, "ctc set b");
        set_mode(4'd4, 2'b10, 2'b10);
        meas(16);
        meas(16);
        chk(hi, 0, "ctc clear");
        chk(wave_out_b, 1'b0, "ctc clear b");
    endtask : t_ctc

    // clear lands one tick after the match is seen: width is cmp+1
    task automatic t_fast();
        pwm_case(4'd5, 16'h0040, 2'b10, 256);
        chk(hi, 32'h41, "fast non-inverted");
        pwm_case(4'd5, 16'h0040, 2'b11, 256);
        chk(hi, 256 - 32'h41, "fast inverted");
        pwm_case(4'd5, 16'h00ff, 2'b10, 256);
        chk(hi, 256, "fast compare at top");
    endtask : t_fast

    // 8-bit dual slope: period 510, symmetric about TOP; last a mode 9 toggle case with TOP 16
    task automatic t_dual();
        pwm_case(4'd1, 16'h0040, 2'b10, 510);
        chk(hi, 128, "dual non-inverted");
        pwm_case(4'd1, 16'h0040, 2'b11, 510);
        chk(hi, 382, "dual inverted");
        pwm_case(4'd1, 16'h0000, 2'b10, 510);
        chk(hi, 0, "dual at bottom");
        pwm_case(4'd1, 16'h00ff, 2'b10, 510);
        chk(hi, 510, "dual at top");
        pwm_case(4'd9, 16'h0010, 2'b01, 64);
        chk(tg, 2, "dual toggle");
    endtask : t_dual

    task automatic t_ovf();
        logic [31:0] held;
        pwm_case(4'd5, 16'h0010, 2'b00, 256);
        chk(overflow_flag, 1'b1, "overflow set");
        @(posedge aclk);
        timer_tick <= 1'b0;
        wr(tmw_pkg::ADDR_STATUS, 32'h0000_0001, tmw_pkg::RESP_OKAY);
        rd(tmw_pkg::ADDR_COUNT);
        held = rd_data;
        repeat (20) @(posedge aclk);
        rd(tmw_pkg::ADDR_COUNT);
        chk(rd_data, held, "count frozen");
        chk(overflow_flag, 1'b0, "overflow cleared");
        timer_tick <= 1'b1;
        repeat (300) @(posedge aclk);
        chk(overflow_flag, 1'b1, "overflow again");
    endtask : t_ovf

    // ************************************
    // main sequence and hang guard
    // ************************************
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_pins();
        t_ctc();
        t_fast();
        t_dual();
        t_ovf();
        summarize();
    end

    initial begin
        int cycles;
        cycles = 0;
        while (cycles < LIMIT) begin
            @(posedge aclk);
            cycles++;
        end
        fail_count++;
        $display("MISMATCH at %0t: run did not finish", $time);
        summarize();
    end
endmodule : testbench
`default_nettype wire
